/* File: src/gauge_port_pkg.sv */
// Shared constants for the gauge driver serial port
package gauge_port_pkg;
  localparam int WORD_BITS     = 16;           // Serial word length
  localparam int ADDR_MSB      = 15;           // Destination field top bit
  localparam int ADDR_LSB      = 13;           // Destination field low bit
  localparam int ADDR_BITS     = 3;
  localparam int NUM_REGS      = 8;
  localparam int CNT_BITS      = 12;           // Frame bit counter width
  localparam int CLK_MHZ       = 100;          // Local clock rate
  localparam real CS_GAP_US    = 5.0;          // Least chip-select high time
  localparam int CS_GAP_CYC    = int'(CS_GAP_US * CLK_MHZ);  // Whole cycles; a real cast rounds, never truncates
  localparam int SCK_HALF_CYC  = 50;           // Master clock phase timer reload; each phase lasts 51 cycles, about 0.98 MHz
  localparam real CAL_PULSE_US = 8.0;          // Calibration low pulse
  localparam int CAL_PULSE_CYC = int'(CAL_PULSE_US * CLK_MHZ);
  localparam int CAL_BIT       = 3;            // calibrate_request_bit in config word
  localparam int TRIM_BIT      = 4;            // clock_trim_select_bit in config word
  localparam logic [2:0] ADDR_CONFIG = 3'h0;   // power_enable_calib_config_word
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] REG_RST    = 16'h0000;
  localparam int FIFO_DEPTH    = 32;
endpackage : gauge_port_pkg

/* File: src/gauge_link_if.sv */
// Serial link between master and gauge driver port
`timescale 1ns/1ps
interface gauge_link_if;
  logic cs_n;      // Chip select, low active
  logic sclk;      // Serial clock from the master
  logic si;        // Master to device data
  logic so_o;      // Device output value
  logic so_oe;     // Device output enable
  logic rst_pin_n; // Device reset pin, low active
  modport device (input cs_n, input sclk, input si, input rst_pin_n, output so_o, output so_oe);
  modport master (output cs_n, output sclk, output si, output rst_pin_n, input so_o, input so_oe);
endinterface : gauge_link_if

/* File: src/gauge_port_device.sv */
// Device end: serial slave port with word latching and status return
`timescale 1ns/1ps
module gauge_port_device
  import gauge_port_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  gauge_link_if.device               link,
  input  wire logic [WORD_BITS-1:0]  status_word,
  output logic [WORD_BITS-1:0]       config_word,
  output logic                       word_valid,
  output logic [WORD_BITS-1:0]       word_data,
  input  wire logic                  word_ready,
  output logic                       calib_active,
  output logic [15:0]                calib_cycles
);
  // Three-stage synchronisers; the first stage feeds only the second
  logic [2:0] cs_s_r, sck_s_r, si_s_r, rp_s_r;
  logic       cs_q_r, sck_q_r, rp_q_r;
  always_ff @(posedge clock) begin
    cs_s_r  <= {cs_s_r[1:0], link.cs_n};
    sck_s_r <= {sck_s_r[1:0], link.sclk};
    si_s_r  <= {si_s_r[1:0], link.si};
    rp_s_r  <= {rp_s_r[1:0], link.rst_pin_n};
  end

  // Filtered levels change only when stages two and three agree
  wire cs_agree  = (cs_s_r[1] == cs_s_r[2]);
  wire sck_agree = (sck_s_r[1] == sck_s_r[2]);
  wire rp_agree  = (rp_s_r[1] == rp_s_r[2]);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_q_r  <= 1'b1;
      sck_q_r <= 1'b0;
      rp_q_r  <= 1'b1;
    end else begin
      if (cs_agree) cs_q_r <= cs_s_r[2];
      if (sck_agree) sck_q_r <= sck_s_r[2];
      if (rp_agree) rp_q_r <= rp_s_r[2];
    end
  end

  // Pin reset and local reset act alike on all port state past the filters; the pin is filtered like the link
  wire  rp_now   = rp_agree ? rp_s_r[2] : rp_q_r;
  wire  port_rst = !rst_n || !rp_now;
  wire  cs_now   = cs_agree ? cs_s_r[2] : cs_q_r;
  // Edges come from sampled levels, so each link clock phase must last at least two local cycles
  wire  sck_now  = sck_agree ? sck_s_r[2] : sck_q_r;
  wire  active   = !cs_now;
  wire  sck_fall = active && sck_q_r && !sck_now;
  wire  sck_rise = active && !sck_q_r && sck_now;
  wire  cs_fall  = cs_q_r && !cs_now;
  wire  cs_rise  = !cs_q_r && cs_now;

  logic [WORD_BITS-1:0] in_sr_r, out_sr_r;
  logic [CNT_BITS-1:0]  bits_r;
  logic                 first_rise_r, so_r, so_oe_r;
  logic [WORD_BITS-1:0] regs_r [NUM_REGS];
  logic                 cal_armed_r;
  logic [15:0]          cal_cnt_r;

  // Receive shifter, most significant bit enters first
  wire [WORD_BITS-1:0] in_sr_nxt = {in_sr_r[WORD_BITS-2:0], si_s_r[2]};
  wire                 whole     = (bits_r != '0) && (bits_r[3:0] == 4'h0);
  wire [ADDR_BITS-1:0] dest      = in_sr_r[ADDR_MSB:ADDR_LSB];
  // A latched config word with the request bit arms calibration
  wire                 cal_req   = (dest == ADDR_CONFIG) && in_sr_r[CAL_BIT];
  // Words after the status word come from the receive shifter: FIFO daisy chain
  wire [WORD_BITS-1:0] out_load  = first_rise_r ? status_word : in_sr_r;

  always_ff @(posedge clock) begin
    if (port_rst || cs_fall) begin
      bits_r       <= '0;
      first_rise_r <= 1'b1;
      if (port_rst) in_sr_r <= '0;
    end else if (sck_fall) begin
      in_sr_r <= in_sr_nxt;
      bits_r  <= bits_r + 1'b1;
    end else if (sck_rise) begin
      first_rise_r <= 1'b0;
    end
  end

  // Output shifter reloads every sixteen rising edges
  always_ff @(posedge clock) begin
    if (port_rst) begin
      out_sr_r <= STATUS_RST;
      so_r     <= 1'b0;
    end else if (sck_rise) begin
      if (bits_r[3:0] == 4'h0) begin
        so_r     <= out_load[WORD_BITS-1];
        out_sr_r <= {out_load[WORD_BITS-2:0], 1'b0};
      end else begin
        so_r     <= out_sr_r[WORD_BITS-1];
        out_sr_r <= {out_sr_r[WORD_BITS-2:0], 1'b0};
      end
    end
  end

  // Output enable follows filtered chip select
  always_ff @(posedge clock) begin
    if (port_rst) so_oe_r <= 1'b0;
    else          so_oe_r <= active;
  end
  assign link.so_o  = so_r;
  assign link.so_oe = so_oe_r;

  // Register file latched on chip select rise; bad frames leave it alone
  always_ff @(posedge clock) begin
    if (port_rst) begin
      for (int i = 0; i < NUM_REGS; i++) regs_r[i] <= REG_RST;
    end else if (cs_rise && whole && !cal_armed_r) begin
      regs_r[dest] <= in_sr_r;
    end
  end
  assign config_word = regs_r[ADDR_CONFIG];

  // Calibration: the next chip-select low pulse is measured in local cycles
  always_ff @(posedge clock) begin
    if (port_rst) begin
      cal_armed_r  <= 1'b0;
      calib_active <= 1'b0;
      calib_cycles <= '0;
      cal_cnt_r    <= '0;
    end else if (cs_rise && whole && cal_req && !cal_armed_r) begin
      cal_armed_r <= 1'b1;
    end else if (cal_armed_r && cs_fall) begin
      calib_active <= 1'b1;
      cal_cnt_r    <= 16'h0001;                                     // The fall cycle itself counts
    end else if (calib_active && cs_rise) begin
      calib_active <= 1'b0;
      cal_armed_r  <= 1'b0;
      calib_cycles <= cal_cnt_r;
    end else if (calib_active) begin
      cal_cnt_r <= cal_cnt_r + 1'b1;
    end
  end

  // Handshake toward the oscillator domain: hold word until taken
  always_ff @(posedge clock) begin
    if (port_rst) begin
      word_valid <= 1'b0;
      word_data  <= '0;
    end else if (cs_rise && whole && !cal_armed_r) begin
      word_valid <= 1'b1;
      word_data  <= in_sr_r;
    end else if (word_ready) begin
      word_valid <= 1'b0;
    end
  end
endmodule : gauge_port_device

/* File: src/gauge_word_fifo.sv */
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module gauge_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, rd_r;
  logic [AW:0]      cnt_r;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  // Storage writes need no reset
  always_ff @(posedge clock) begin
    if (push) mem_r[wr_r] <= in_data;
  end
  // Pointers and fill count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop)  rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : gauge_word_fifo

/* File: src/gauge_port_master.sv */
// Master end: sends queued words as frames and returns read words
`timescale 1ns/1ps
module gauge_port_master
  import gauge_port_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  gauge_link_if.master              link,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire logic [WORD_BITS-1:0] cmd_data,
  input  wire logic                 cal_go,
  input  wire logic                 dev_reset,
  output logic                      rsp_valid,
  output logic [WORD_BITS-1:0]      rsp_data,
  output logic                      busy
);
  typedef enum {M_IDLE, M_LOW, M_HIGH, M_END, M_GAP, M_CAL} mstate_t;
  mstate_t st_r;
  logic [15:0] tmr_r;
  logic [4:0]  bit_r;
  logic [WORD_BITS-1:0] tx_r, rx_r;
  logic cs_r, sck_r, rstp_r;
  logic so_s_r [3];
  logic so_q_r;
  logic f_valid, f_ready;
  logic [WORD_BITS-1:0] f_data;

  // Command queue absorbs bursts; back-pressure reaches cmd_ready
  gauge_word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) cmd_q (
    .clock(clock), .rst_n(rst_n), .in_valid(cmd_valid), .in_ready(cmd_ready),
    .in_data(cmd_data), .out_valid(f_valid), .out_ready(f_ready), .out_data(f_data));

  // Return data is sampled through three flops, two agreeing
  always_ff @(posedge clock) begin
    so_s_r[0] <= link.so_o;
    so_s_r[1] <= so_s_r[0];
    so_s_r[2] <= so_s_r[1];
    if (so_s_r[1] == so_s_r[2]) so_q_r <= so_s_r[2];
  end

  wire tmr_done = (tmr_r == '0);
  // Data moves mid low phase: changing it with the clock fall would beat the device's sampling
  wire mid_low  = (tmr_r == 16'(SCK_HALF_CYC / 2)) && (bit_r != 5'(WORD_BITS));
  assign f_ready = (st_r == M_IDLE) && !cal_go && !dev_reset && f_valid;

  // Frame sequencer: clock low around every chip select change
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= M_IDLE; cs_r <= 1'b1; sck_r <= 1'b0; rstp_r <= 1'b1;
      tmr_r <= '0; bit_r <= '0; tx_r <= '0; rx_r <= '0;
      rsp_valid <= 1'b0; rsp_data <= '0; busy <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (!tmr_done) tmr_r <= tmr_r - 1'b1;
      case (st_r)
        M_IDLE: begin
          busy   <= 1'b0;
          rstp_r <= !dev_reset;
          if (cal_go) begin
            st_r <= M_CAL; cs_r <= 1'b0; busy <= 1'b1;
            tmr_r <= 16'(CAL_PULSE_CYC - 1);                        // Low for exactly the pulse length
          end else if (f_ready) begin
            st_r <= M_LOW; cs_r <= 1'b0; tx_r <= f_data; busy <= 1'b1;
            bit_r <= 5'(WORD_BITS); tmr_r <= 16'(SCK_HALF_CYC);
          end
        end
        M_LOW: begin
          if (mid_low) tx_r <= {tx_r[WORD_BITS-2:0], 1'b0};
          if (tmr_done) begin
            sck_r <= 1'b1; st_r <= M_HIGH; tmr_r <= 16'(SCK_HALF_CYC);
          end
        end
        M_HIGH: if (tmr_done) begin
          sck_r <= 1'b0;
          rx_r  <= {rx_r[WORD_BITS-2:0], so_q_r};
          bit_r <= bit_r - 1'b1; tmr_r <= 16'(SCK_HALF_CYC);
          st_r  <= (bit_r == 5'h01) ? M_END : M_LOW;
        end
        M_END: if (tmr_done) begin
          cs_r <= 1'b1; rsp_valid <= 1'b1; rsp_data <= rx_r;
          st_r <= M_GAP; tmr_r <= 16'(CS_GAP_CYC);
        end
        M_CAL: if (tmr_done) begin
          cs_r <= 1'b1; st_r <= M_GAP; tmr_r <= 16'(CS_GAP_CYC);
        end
        M_GAP: if (tmr_done) st_r <= M_IDLE;
        default: st_r <= M_IDLE;
      endcase
    end
  end

  assign link.cs_n      = cs_r;
  assign link.sclk      = sck_r;
  assign link.si        = tx_r[WORD_BITS-1];
  assign link.rst_pin_n = rstp_r;
endmodule : gauge_port_master

/* File: verification/gauge_port_asserts.sv */
// Link protocol assertions for the gauge serial port
`timescale 1ns/1ps
module gauge_port_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic rst_pin_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [11:0] gap_r;
  logic [3:0]  bits_r;
  // Idle time and clock falls per frame; gap starts full so reset never looks like a short gap
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gap_r  <= 12'hFFF;
      bits_r <= 4'h0;
    end else begin
      gap_r  <= !cs_n ? 12'h000 : (gap_r == 12'hFFF ? gap_r : gap_r + 12'h001);
      bits_r <= cs_n ? 4'h0 : bits_r + {3'h0, $fell(sclk)};
    end
  end
  a_so_released: assert property (cs_n [*8] |-> !so_oe) else $error("output driven while deselected");
  a_so_driven: assert property (!cs_n [*8] |-> so_oe) else $error("output not driven in frame");
  a_cs_fall_sclk: assert property ($fell(cs_n) |-> !sclk && !$past(sclk)) else $error("select fell, clock high");
  a_cs_rise_sclk: assert property ($rose(cs_n) |-> !sclk) else $error("select rose with clock high");
  a_sclk_idle: assert property (cs_n && $past(cs_n) |-> $stable(sclk)) else $error("clock moved while idle");
  a_so_on_rise: assert property (!cs_n && so_oe && $past(so_oe) && $changed(so_o) |-> sclk)
    else $error("output changed in clock low phase");
  a_si_held: assert property (sclk && $past(sclk) |-> $stable(si)) else $error("input moved in high phase");
  a_frame_whole: assert property ($rose(cs_n) |-> bits_r == 4'h0) else $error("frame not whole words");
  a_cs_gap: assert property ($fell(cs_n) |-> gap_r >= 12'h1F4) else $error("select gap too short");
  a_reset_idle: assert property (!rst_pin_n |-> cs_n) else $error("reset pin low in frame");
endmodule : gauge_port_asserts

/* File: verification/gauge_driver_serial_port_tb.sv */
// Bench for both link ends, a rule-breaking link, calibration and a mid-run reset
`timescale 1ns/1ps
module gauge_driver_serial_port_tb;
  import gauge_port_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid, cmd_ready, dev_reset, rsp_valid, word_valid, word_ready;
  logic        cal_go, busy, calib_active;
  logic [15:0] cmd_data, rsp_data, status_word, config_word, word_data, status_b, config_b;
  logic [15:0] calib_cycles, cfg_m;
  logic [15:0] got_q[$], rsp_q[$];
  logic [31:0] seed = 32'h0000B53B;
  int          n_errors = 0;
  int          comparisons = 0;
  gauge_link_if link();
  gauge_link_if link_b();
  gauge_port_master u_gauge_port_master (.clock(clock), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .cal_go(cal_go), .dev_reset(dev_reset), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .busy(busy));
  gauge_port_device u_gauge_port_device (.clock(clock), .rst_n(rst_n), .link(link), .status_word(status_word),
    .config_word(config_word), .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready),
    .calib_active(calib_active), .calib_cycles(calib_cycles));
  // Second device faces the bench, which breaks framing on purpose
  gauge_port_device u_gauge_port_device_b (.clock(clock), .rst_n(rst_n), .link(link_b), .status_word(status_b),
    .config_word(config_b), .word_valid(), .word_data(), .word_ready(1'b1), .calib_active(), .calib_cycles());
  gauge_port_asserts u_gauge_port_asserts (.clock(clock), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
    .si(link.si), .so_o(link.so_o), .so_oe(link.so_oe), .rst_pin_n(link.rst_pin_n));
  always #5 clock = ~clock;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // Random stalls on the device word handshake; capture both user-side results
  always @(negedge clock) word_ready = rnd() > 32'h7FFFFFFF;
  always @(posedge clock) if (word_valid === 1'b1 && word_ready) got_q.push_back(word_data);
  always @(posedge clock) if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
  task automatic send(input logic [15:0] w);
    int i;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_data = w;
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask : send
  // Four words back to back; even ones hit the config word with calibration request clear
  task automatic batch();
    logic [15:0] w[4];
    int i;
    status_word = 16'(rnd());
    for (i = 0; i < 4; i++) begin
      w[i] = 16'(rnd()) & (i % 2 == 0 ? 16'h1FF7 : 16'hFFF7);
      if (w[i][15:13] == ADDR_CONFIG) cfg_m = w[i];
      send(w[i]);
    end
    for (i = 0; i < 12000 && got_q.size() < 4; i++) @(negedge clock);
    for (i = 0; i < 4; i++) begin
      check(rsp_q.pop_front(), status_word);
      check(got_q.pop_front(), w[i]);
    end
    check(config_word, cfg_m);
  endtask : batch
  // Bench-made link clock, 125 ns, unrelated to the system clock
  task automatic frame_b(input int n, input logic [31:0] d, output logic [31:0] q);
    int i;
    q = '0;
    link_b.cs_n = 1'b0;
    #250 check(link_b.so_oe, 1'b1);
    for (i = n - 1; i >= 0; i--) begin
      link_b.si = d[i];
      #31.25 link_b.sclk = 1'b1;
      #62.5 q = {q[30:0], link_b.so_o};
      link_b.sclk = 1'b0;
      #31.25;
    end
    #250 link_b.cs_n = 1'b1;
    link_b.si = ~link_b.si; // Released line shows no stale data
    #5000;
  endtask : frame_b
  task automatic run_b();
    logic [31:0] q, d;
    int n;
    status_b = 16'(rnd());
    d = rnd() & 32'hFFFF1F17; // Low byte top bits zero so short frames would hit the config word
    frame_b(32, d, q);
    check(q, {status_b, d[31:16]});
    check(config_b, d[15:0]);
    for (n = 8; n < 32; n += 16) begin
      frame_b(n, 32'h0, q);
      check(config_b, d[15:0]);
    end
    repeat (20) begin
      link_b.si = ~link_b.si;
      #62.5 link_b.sclk = 1'b1;
      #62.5 link_b.sclk = 1'b0;
    end
    #1000 check(config_b, d[15:0]);
    check(link_b.so_oe, 1'b0);
  endtask : run_b
  // Arm calibration by the request bit, then the master sends one measured select pulse
  task automatic cal_run();
    logic [15:0] w;
    int i;
    w = (16'(rnd()) & 16'h1FFF) | (16'h0001 << CAL_BIT);
    send(w);
    for (i = 0; i < 4000 && got_q.size() < 1; i++) @(negedge clock);
    check(got_q.pop_front(), w);
    check(rsp_q.pop_front(), status_word);
    for (i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clock);
    cal_go = 1'b1;
    @(negedge clock);
    cal_go = 1'b0;
    repeat (100) @(negedge clock);
    check(calib_active, 1'b1);
    for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clock);
    check(calib_active, 1'b0);
    check(calib_cycles, 32'(CAL_PULSE_CYC));
    check(32'(got_q.size() + rsp_q.size()), 32'h0);
    check(config_word, w);
  endtask : cal_run
  // Pin reset holds the master idle while its queue fills; two words go out, then a reset flushes the rest
  task automatic fifo_run();
    logic [15:0] m[$];
    int i;
    status_word = 16'(rnd());
    dev_reset = 1'b1;
    cmd_valid = 1'b1;
    for (i = 0; i < 40 && cmd_ready === 1'b1; i++) begin
      cmd_data = 16'(rnd()) & 16'hFFF7;
      m.push_back(cmd_data);
      @(negedge clock);
    end
    cmd_valid = 1'b0;
    check(32'(m.size()), 32'(FIFO_DEPTH));
    repeat (400) @(negedge clock);
    dev_reset = 1'b0;
    for (i = 0; i < 6000 && got_q.size() < 2; i++) @(negedge clock);
    for (i = 0; i < 2; i++) begin
      check(got_q.pop_front(), m.pop_front());
      check(rsp_q.pop_front(), status_word);
    end
    rst_n = 1'b0;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (3000) @(negedge clock);
    check(32'(rsp_q.size() + got_q.size()), 32'h0);
    check(config_word, REG_RST);
  endtask : fifo_run
  initial begin
    #800000;
    n_errors++;
    results();
  end
  initial begin
    {cmd_valid, dev_reset, word_ready, cal_go} = 4'h0;
    {cmd_data, status_word, status_b, cfg_m} = '0;
    {link_b.cs_n, link_b.sclk, link_b.si, link_b.rst_pin_n} = 4'h9;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    batch();
    dev_reset = 1'b1;
    // Long enough for the master to finish its gap and then hold the pin low
    repeat (1000) @(negedge clock);
    dev_reset = 1'b0;
    repeat (600) @(negedge clock);
    cfg_m = REG_RST;
    check(config_word, cfg_m);
    batch();
    run_b();
    cal_run();
    fifo_run();
    results();
  end
endmodule : gauge_driver_serial_port_tb
